// *** core/afc_top.sv ***
// Front-end control, sinc3 decimator and register file of the converter
// Notes on behaviour
// - Primary diagnostic enables follow primary two-bit field.
// - Primary field zero: both diagnostic currents off.
// - Primary field one: first input current only.
// - Primary field three: both input currents on.
// - Aux diagnostic enables follow aux two-bit field.
// - Decimation factor from filter control bits six-zero.
// - Chop mode swaps inputs each output period.
// - Chop mode averages new and previous outputs.
// - Four-bit gain field selects ten gains.
// - Source zero enabled only by bit six.
// - Source one enabled only by bit seven.
// - Four-bit magnitude field, 200 uA steps, 1 mA.
// - Route bits steer either source to one pin.
`timescale 1ns/100ps
`default_nettype none
module afc_top
  import afc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [DW-1:0] wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_we_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic [DW-1:0]      wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          mod_bit_i,
  output logic [1:0]         pri_diag_en_o,
  output logic [1:0]         aux_diag_en_o,
  output logic [GAIN_N-1:0]  gain_sel_o,
  output logic               chop_swap_o,
  output logic [1:0]         excite_en_o,
  output logic [3:0]         excitation_magnitude_o,
  output logic [1:0]         excite_pin_a_o,
  output logic [1:0]         excite_pin_b_o
);
  // Register state
  logic [7:0]       pri_ctrl_ff;
  logic [7:0]       aux_ctrl_ff;
  logic [7:0]       flt_ctrl_ff;
  logic [7:0]       exc_ctrl_ff;
  logic             rdy_ff;
  afc_wb_st_t       wb_st_ff;
  afc_wb_st_t       nxt_wb_st;

  // Bus decode
  wire req      = wb_cyc_i & wb_stb_i;
  wire wr_take  = req & wb_we_i & (wb_st_ff == AFC_WB_ACK) & wb_sel_i[0];
  wire rd_start = req & (wb_st_ff == AFC_WB_IDLE);
  wire hit_pri  = (wb_adr_i == OFS_PRI_CTRL);
  wire hit_aux  = (wb_adr_i == OFS_AUX_CTRL);
  wire hit_flt  = (wb_adr_i == OFS_FLT_CTRL);
  wire hit_exc  = (wb_adr_i == OFS_EXC_CTRL);
  wire hit_res  = (wb_adr_i == OFS_RESULT);
  wire hit_sta  = (wb_adr_i == OFS_STATUS);
  wire rd_res   = req & ~wb_we_i & hit_res & (wb_st_ff == AFC_WB_ACK);

  // Classic cycle: one wait state, ack for one cycle, then idle
  always_comb begin
    nxt_wb_st = AFC_WB_IDLE;
    case (wb_st_ff)
      AFC_WB_IDLE: nxt_wb_st = req ? AFC_WB_ACK : AFC_WB_IDLE;
      AFC_WB_ACK:  nxt_wb_st = AFC_WB_IDLE;
      default:     nxt_wb_st = AFC_WB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_st_ff <= AFC_WB_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      wb_st_ff <= nxt_wb_st;
      wb_ack_o <= (nxt_wb_st == AFC_WB_ACK);
    end
  end

  // Writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_ctrl_ff <= CTRL_RST;
      aux_ctrl_ff <= CTRL_RST;
      flt_ctrl_ff <= {1'b0, DEC_RST};
      exc_ctrl_ff <= CTRL_RST;
    end else if (wr_take) begin
      if (hit_pri) pri_ctrl_ff <= wb_dat_i[7:0];
      if (hit_aux) aux_ctrl_ff <= wb_dat_i[7:0];
      if (hit_flt) flt_ctrl_ff <= wb_dat_i[7:0];
      if (hit_exc) exc_ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // Field extraction
  wire [1:0]       pri_diag_sel = pri_ctrl_ff[PRI_DIAG_LSB +: 2];
  wire [1:0]       aux_diag_sel = aux_ctrl_ff[AUX_DIAG_LSB +: 2];
  wire [3:0]       gain_code    = pri_ctrl_ff[PRI_GAIN_LSB +: 4];
  wire [DEC_W-1:0] dec_word     = flt_ctrl_ff[FLT_DEC_LSB +: DEC_W];
  wire             chop_en      = flt_ctrl_ff[FLT_CHOP_BIT];
  wire [3:0]       mag_code     = exc_ctrl_ff[EXC_MAG_LSB +: 4];
  wire             src0_route   = exc_ctrl_ff[EXC_RT0_BIT];
  wire             src1_route   = exc_ctrl_ff[EXC_RT1_BIT];
  wire             src0_en      = exc_ctrl_ff[EXC_EN0_BIT];
  wire             src1_en      = exc_ctrl_ff[EXC_EN1_BIT];

  // Diagnostic enables: bit 0 first input, bit 1 second input
  wire [1:0] nxt_pri_diag = (pri_diag_sel == DIAG_OFF) ? 2'b00 : pri_diag_sel;
  wire [1:0] nxt_aux_diag = (aux_diag_sel == DIAG_OFF) ? 2'b00 : aux_diag_sel;

  // Reserved gain codes fall back to unity so the amplifier never floats
  wire             gain_ok       = (gain_code <= GAIN_MAX);
  wire [3:0]       gain_eff      = gain_ok ? gain_code : 4'h0;
  wire [GAIN_N-1:0] nxt_gain_sel = GAIN_N'(1) << gain_eff;

  // Magnitude clamped into 200 uA .. 1 mA steps
  wire [3:0] nxt_mag = (mag_code < MAG_MIN) ? MAG_MIN :
                       (mag_code > MAG_MAX) ? MAG_MAX : mag_code;

  // Route bit low: own pin; high: the other pin
  wire [1:0] nxt_pin_a = {src1_en & src1_route, src0_en & ~src0_route};
  wire [1:0] nxt_pin_b = {src1_en & ~src1_route, src0_en & src0_route};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_diag_en_o          <= 2'b00;
      aux_diag_en_o          <= 2'b00;
      gain_sel_o             <= GAIN_N'(1);
      excite_en_o            <= 2'b00;
      excitation_magnitude_o <= MAG_MIN;
      excite_pin_a_o         <= 2'b00;
      excite_pin_b_o         <= 2'b00;
    end else begin
      pri_diag_en_o          <= nxt_pri_diag;
      aux_diag_en_o          <= nxt_aux_diag;
      gain_sel_o             <= nxt_gain_sel;
      excite_en_o            <= {src1_en, src0_en};
      excitation_magnitude_o <= nxt_mag;
      excite_pin_a_o         <= nxt_pin_a;
      excite_pin_b_o         <= nxt_pin_b;
    end
  end

  // Modulator bit crosses in through two flops
  logic mod_meta_ff;
  logic mod_sync_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_meta_ff <= 1'b0;
      mod_sync_ff <= 1'b0;
    end else begin
      mod_meta_ff <= mod_bit_i;
      mod_sync_ff <= mod_meta_ff;
    end
  end

  // Modulator rate enable
  logic [4:0] div_ff;
  wire        mod_tick = (div_ff == MOD_DIV_LAST);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= mod_tick ? 5'h00 : 5'(div_ff + 5'h01);
    end
  end

  // Out-of-range word is flagged; hardware still clamps to the minimum
  wire             dec_low = (dec_word < DEC_MIN);
  wire [DEC_W-1:0] dec_eff = dec_low ? DEC_MIN : dec_word;

  // Sinc3 integrators at the modulator rate; wraparound is harmless
  afc_smp_t   int1_ff;
  afc_smp_t   int2_ff;
  afc_smp_t   int3_ff;
  afc_smp_t   dly1_ff;
  afc_smp_t   dly2_ff;
  afc_smp_t   dly3_ff;
  logic [DEC_W-1:0] dcnt_ff;
  logic       phase_ff;
  logic       smp_vld_ff;
  afc_smp_t   smp_ff;
  logic       smp_ph_ff;
  wire afc_smp_t in_val = mod_sync_ff ? SMP_POS : SMP_NEG;
  wire        dec_tick  = mod_tick & (dcnt_ff >= DEC_W'(dec_eff - DEC_W'(1)));
  wire afc_smp_t comb1  = int3_ff - dly1_ff;
  wire afc_smp_t comb2  = comb1 - dly2_ff;
  wire afc_smp_t comb3  = comb2 - dly3_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int1_ff <= '0;
      int2_ff <= '0;
      int3_ff <= '0;
    end else if (mod_tick) begin
      int1_ff <= int1_ff + in_val;
      int2_ff <= int2_ff + int1_ff;
      int3_ff <= int3_ff + int2_ff;
    end
  end

  // Decimation count and comb section
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcnt_ff <= '0;
      dly1_ff <= '0;
      dly2_ff <= '0;
      dly3_ff <= '0;
    end else if (mod_tick) begin
      dcnt_ff <= dec_tick ? '0 : DEC_W'(dcnt_ff + DEC_W'(1));
      if (dec_tick) begin
        dly1_ff <= int3_ff;
        dly2_ff <= comb1;
        dly3_ff <= comb2;
      end
    end
  end

  // Chop phase flips at each output period; sample keeps its own phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff   <= 1'b0;
      smp_vld_ff <= 1'b0;
      smp_ff     <= '0;
      smp_ph_ff  <= 1'b0;
    end else begin
      smp_vld_ff <= dec_tick;
      if (dec_tick) begin
        smp_ff    <= comb3;
        smp_ph_ff <= phase_ff;
        phase_ff  <= chop_en & ~phase_ff;
      end else if (!chop_en) begin
        phase_ff  <= 1'b0;
      end
    end
  end

  assign chop_swap_o = phase_ff;

  afc_smp_if smp_bus ();
  assign smp_bus.valid = smp_vld_ff;
  assign smp_bus.data  = smp_ff;
  assign smp_bus.phase = smp_ph_ff;
  assign smp_bus.chop  = chop_en;

  afc_smp_t result;
  logic     res_strobe;
  afc_chop_avg u_avg (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .smp      (smp_bus),
    .result_o (result),
    .strobe_o (res_strobe)
  );

  // Ready flag: a new result in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_ff <= 1'b0;
    end else if (res_strobe) begin
      rdy_ff <= 1'b1;
    end else if (rd_res) begin
      rdy_ff <= 1'b0;
    end
  end

  // Read mux
  logic [DW-1:0] status_w;
  always_comb begin
    status_w               = '0;
    status_w[STA_RDY_BIT]  = rdy_ff;
    status_w[STA_PH_BIT]   = phase_ff;
    status_w[STA_DERR_BIT] = dec_low;
  end

  wire [DW-1:0] rd_data =
    hit_pri ? DW'(pri_ctrl_ff) :
    hit_aux ? DW'(aux_ctrl_ff) :
    hit_flt ? DW'(flt_ctrl_ff) :
    hit_exc ? DW'(exc_ctrl_ff) :
    hit_res ? DW'($unsigned(result)) :
    hit_sta ? status_w : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_start && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end
endmodule : afc_top
`default_nettype wire

// *** inc/afc_pkg.sv ***
// Constants, field layout and types of the front-end filter control block
package afc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PRI_CTRL = 8'h00;
  localparam logic [7:0] OFS_AUX_CTRL = 8'h04;
  localparam logic [7:0] OFS_FLT_CTRL = 8'h08;
  localparam logic [7:0] OFS_EXC_CTRL = 8'h0C;
  localparam logic [7:0] OFS_RESULT   = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  // primary_conv_control fields
  localparam int PRI_GAIN_LSB = 0;
  localparam int PRI_DIAG_LSB = 4;
  // aux_conv_control fields
  localparam int AUX_DIAG_LSB = 0;
  // filter_control fields
  localparam int FLT_DEC_LSB  = 0;
  localparam int FLT_CHOP_BIT = 7;
  // excitation_control fields
  localparam int EXC_MAG_LSB  = 0;
  localparam int EXC_RT0_BIT  = 4;
  localparam int EXC_RT1_BIT  = 5;
  localparam int EXC_EN0_BIT  = 6;
  localparam int EXC_EN1_BIT  = 7;
  // status fields
  localparam int STA_RDY_BIT  = 0;
  localparam int STA_PH_BIT   = 1;
  localparam int STA_DERR_BIT = 2;
  // Widths
  localparam int DW     = 32;
  localparam int SMP_W  = 24;
  localparam int DEC_W  = 7;
  localparam int GAIN_N = 10;
  // Reset values and limits
  localparam logic [7:0]       CTRL_RST  = 8'h00;
  localparam logic [DEC_W-1:0] DEC_RST   = 7'h7F;
  localparam logic [DEC_W-1:0] DEC_MIN   = 7'h03;
  localparam logic [3:0]       GAIN_MAX  = 4'h9;
  localparam logic [3:0]       MAG_MIN   = 4'h1;
  localparam logic [3:0]       MAG_MAX   = 4'h5;
  localparam logic [1:0]       DIAG_OFF  = 2'h0;
  // Modulator sampling rate
  localparam int CLK_HZ  = 10_000_000;
  localparam int MOD_HZ  = 500_000;
  localparam int MOD_DIV = CLK_HZ / MOD_HZ;
  localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_DIV - 1);
  localparam logic [SMP_W-1:0] SMP_POS = 24'h00_0001;
  localparam logic [SMP_W-1:0] SMP_NEG = 24'hFF_FFFF;
  typedef logic signed [SMP_W-1:0] afc_smp_t;
  typedef enum logic {
    AFC_WB_IDLE = 1'b0,
    AFC_WB_ACK  = 1'b1
  } afc_wb_st_t;
endpackage : afc_pkg

// *** inc/afc_smp_if.sv ***
// Decimator sample carrier between decimator and chop averager
`timescale 1ns/100ps
`default_nettype none
interface afc_smp_if;
  import afc_pkg::*;
  logic     valid;
  afc_smp_t data;
  logic     phase;
  logic     chop;
  modport src (output valid, output data, output phase, output chop);
  modport dst (input valid, input data, input phase, input chop);
endinterface : afc_smp_if
`default_nettype wire

// *** core/afc_chop_avg.sv ***
// Chop averaging stage behind the sinc3 decimator
`timescale 1ns/100ps
`default_nettype none
module afc_chop_avg
  import afc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  afc_smp_if.dst    smp,
  output afc_smp_t  result_o,
  output logic      strobe_o
);
  afc_smp_t          prev_ff;
  logic              prev_vld_ff;
  wire afc_smp_t     corr;
  wire [SMP_W:0]     sum;
  wire afc_smp_t     avg;
  // Swapped phase carries negated signal; undo so only offset alternates
  assign corr = smp.phase ? -smp.data : smp.data;
  assign sum  = {corr[SMP_W-1], corr} + {prev_ff[SMP_W-1], prev_ff};
  assign avg  = sum[SMP_W:1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff     <= '0;
      prev_vld_ff <= 1'b0;
      result_o    <= '0;
      strobe_o    <= 1'b0;
    end else begin
      strobe_o <= 1'b0;
      if (smp.valid && smp.chop) begin
        prev_ff     <= corr;
        prev_vld_ff <= 1'b1;
        // First sample after enable has no partner
        if (prev_vld_ff) begin
          result_o <= avg;
          strobe_o <= 1'b1;
        end
      end else if (smp.valid) begin
        prev_vld_ff <= 1'b0;
        result_o    <= smp.data;
        strobe_o    <= 1'b1;
      end
    end
  end
endmodule : afc_chop_avg
`default_nettype wire

// *** dv/afc_mod_model.sv ***
// Behavioural modulator standing in for the analog front end
`timescale 1ns/100ps
`default_nettype none
module afc_mod_model (
  input  wire logic clk_i,
  input  wire logic level_i,
  input  wire logic swap_i,
  output logic      mod_bit_o
);
  // Full-scale input; swapped inputs reverse the polarity seen by the modulator
  always_ff @(posedge clk_i) begin
    mod_bit_o <= level_i ^ swap_i;
  end
endmodule : afc_mod_model
`default_nettype wire

// *** dv/afc_top_monitor.sv ***
// Port-level assertions for the front-end filter control block
`timescale 1ns/100ps
`default_nettype none
module afc_top_monitor
  import afc_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [DW-1:0] wb_dat_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic          wb_we_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic [1:0]    pri_diag_en_o,
  input wire logic [1:0]    aux_diag_en_o,
  input wire logic [9:0]    gain_sel_o,
  input wire logic          chop_swap_o,
  input wire logic [1:0]    excite_en_o,
  input wire logic [3:0]    excitation_magnitude_o,
  input wire logic [1:0]    excite_pin_a_o,
  input wire logic [1:0]    excite_pin_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A write lands at the edge where ack is seen with lane 0 enabled
  wire logic       wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
  wire logic [3:0] gc_w = wb_dat_i[3:0];
  wire logic [9:0] gx_w = (gc_w > GAIN_MAX) ? 10'h001 : 10'h001 << gc_w;
  wire logic [3:0] mx_w = (gc_w < MAG_MIN) ? MAG_MIN : (gc_w > MAG_MAX) ? MAG_MAX : gc_w;
  wire logic [1:0] pa_w = {wb_dat_i[7] & wb_dat_i[5], wb_dat_i[6] & ~wb_dat_i[4]};
  wire logic [1:0] pb_w = {wb_dat_i[7] & ~wb_dat_i[5], wb_dat_i[6] & wb_dat_i[4]};
  wire logic       pw_w = wr_w && wb_adr_i == OFS_PRI_CTRL;
  wire logic       ew_w = wr_w && wb_adr_i == OFS_EXC_CTRL;
  property p_pri; pw_w |-> ##2 pri_diag_en_o == $past(wb_dat_i[5:4], 2); endproperty
  property p_aux; wr_w && wb_adr_i == OFS_AUX_CTRL |-> ##2 aux_diag_en_o == $past(wb_dat_i[1:0], 2); endproperty
  property p_gain; pw_w |-> ##2 gain_sel_o == $past(gx_w, 2); endproperty
  property p_en; ew_w |-> ##2 excite_en_o == $past(wb_dat_i[7:6], 2); endproperty
  property p_mag; ew_w |-> ##2 excitation_magnitude_o == $past(mx_w, 2); endproperty
  property p_pina; ew_w |-> ##2 excite_pin_a_o == $past(pa_w, 2); endproperty
  property p_pinb; ew_w |-> ##2 excite_pin_b_o == $past(pb_w, 2); endproperty
  property p_rst; $fell(rst_i) |-> excite_en_o == 2'h0 && pri_diag_en_o == 2'h0 && aux_diag_en_o == 2'h0; endproperty
  a_pri: assert property (p_pri) else $error("primary diag enables wrong");
  a_aux: assert property (p_aux) else $error("aux diag enables wrong");
  a_gain: assert property (p_gain) else $error("gain select wrong");
  a_en: assert property (p_en) else $error("excitation enables wrong");
  a_mag: assert property (p_mag) else $error("excitation magnitude wrong");
  a_pina: assert property (p_pina) else $error("pin a routing wrong");
  a_pinb: assert property (p_pinb) else $error("pin b routing wrong");
  a_rst: assert property (p_rst) else $error("enables not clear after reset");
  c_exc: cover property (ew_w);
  c_swap: cover property ($rose(chop_swap_o));
  c_gain: cover property (gain_sel_o == 10'h200);
endmodule : afc_top_monitor
bind afc_top afc_top_monitor i_mon (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .pri_diag_en_o, .aux_diag_en_o, .gain_sel_o, .chop_swap_o, .excite_en_o,
  .excitation_magnitude_o, .excite_pin_a_o, .excite_pin_b_o);
`default_nettype wire

// *** dv/afc_top_tb_top.sv ***
// Self-checking bench for the front-end filter control block
`timescale 1ns/100ps
`default_nettype none
module afc_top_tb_top;
  import afc_pkg::*;
  typedef struct packed {
    logic [7:0] a, d;
    logic [1:0] p, x;
    logic [3:0] g;
    logic [1:0] e;
    logic [3:0] m;
    logic [1:0] pa, pb;
  } afc_row_t;
  logic             clk_i, rst_i, we, cyc, stb, level, mod_bit, prev;
  logic [7:0]       adr;
  logic [31:0]      dat, rd;
  logic [3:0]       sel;
  wire logic [31:0] wb_dat_o;
  wire logic        wb_ack_o, chop_swap_o;
  wire logic [1:0]  pri, aux, en, pa, pb;
  wire logic [9:0]  gain;
  wire logic [3:0]  mag;
  int               error_cnt = 0, checks = 0, n;
  afc_row_t rows [10] = '{
    '{8'h00, 8'h10, 2'h1, 2'h0, 4'h0, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h00, 8'h29, 2'h2, 2'h0, 4'h9, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h00, 8'h35, 2'h3, 2'h0, 4'h5, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h00, 8'h0C, 2'h0, 2'h0, 4'h0, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h04, 8'h03, 2'h0, 2'h3, 4'h0, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h04, 8'h02, 2'h0, 2'h2, 4'h0, 2'h0, 4'h1, 2'h0, 2'h0},
    '{8'h0C, 8'h40, 2'h0, 2'h2, 4'h0, 2'h1, 4'h1, 2'h1, 2'h0},
    '{8'h0C, 8'hC3, 2'h0, 2'h2, 4'h0, 2'h3, 4'h3, 2'h1, 2'h2},
    '{8'h0C, 8'hE5, 2'h0, 2'h2, 4'h0, 2'h3, 4'h5, 2'h3, 2'h0},
    '{8'h0C, 8'h85, 2'h0, 2'h2, 4'h0, 2'h2, 4'h5, 2'h0, 2'h2}};
  afc_top i_dut (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o, .wb_ack_o, .mod_bit_i(mod_bit), .pri_diag_en_o(pri),
    .aux_diag_en_o(aux), .gain_sel_o(gain), .chop_swap_o, .excite_en_o(en), .excitation_magnitude_o(mag),
    .excite_pin_a_o(pa), .excite_pin_b_o(pb));
  afc_mod_model i_mod (.clk_i, .level_i(level), .swap_i(chop_swap_o), .mod_bit_o(mod_bit));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Classic cycle; the answer is awaited under a bound, never assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int t;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h00_0000, d}; sel <= s;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    r = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = '0; sel = 4'h0; level = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({pri, aux, gain, en, mag, pa, pb}, {4'h0, 10'h001, 2'h0, 4'h1, 4'h0}, "reset outputs");
    wb(1'b0, OFS_FLT_CTRL, 8'h00, 4'hF, rd);
    chk(rd, 32'h0000_007F, "filter reset");
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].d, 4'h1, rd);
      @(posedge clk_i);
      chk({pri, aux, gain, en, mag, pa, pb}, {rows[i].p, rows[i].x, 10'h001 << rows[i].g, rows[i].e,
          rows[i].m, rows[i].pa, rows[i].pb}, "outputs");
    end
    // Lane 0 off and unmapped place: both writes must leave state alone
    wb(1'b1, OFS_EXC_CTRL, 8'h00, 4'hE, rd);
    wb(1'b1, 8'h20, 8'h00, 4'h1, rd);
    wb(1'b0, 8'h20, 8'h00, 4'h1, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    wb(1'b0, OFS_EXC_CTRL, 8'h00, 4'h1, rd);
    chk(rd, 32'h0000_0085, "excitation readback");
    // Last pass chops at word 3: corrected samples settle at +5, raw ones alternate
    for (int k = 0; k < 3; k++) begin
      level <= (k != 1);
      wb(1'b1, OFS_FLT_CTRL, (k == 2) ? 8'h83 : 8'(3 + k), 4'h1, rd);
      // Early words are still settling; the last one is judged
      repeat (6) begin
        n = 0;
        do begin
          wb(1'b0, OFS_STATUS, 8'h00, 4'h1, rd);
          n++;
        end while (rd[STA_RDY_BIT] !== 1'b1 && n < 500);
        if (rd[STA_RDY_BIT] !== 1'b1) begin
          error_cnt++;
          wrap_up();
        end
        wb(1'b0, OFS_RESULT, 8'h00, 4'h1, rd);
      end
      chk(rd, (k == 0) ? 32'h0000_001B : (k == 1) ? 32'h00FF_FFC0 : 32'h0000_0005, "sinc3 result");
    end
    n = 0;
    prev = chop_swap_o;
    repeat (800) begin
      @(posedge clk_i);
      if (chop_swap_o !== prev) n++;
      prev = chop_swap_o;
    end
    chk(32'(n inside {[13:14]}), 32'h0000_0001, "swap count");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({en, pri, aux, pa, pb, mag}, {10'h000, 4'h1}, "second reset");
    wrap_up();
  end
endmodule : afc_top_tb_top
`default_nettype wire
